// [verilog/sdi_top.sv]
/*
 * System decode and interrupt block: memory and peripheral selects,
 * access stretching, privilege checks, clock setup and a 32-channel
 * interrupt prioritiser. Assumes one clock, a single-cycle register
 * port and on-chip interrupt sources on clk_sys.
 */
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Selects for flash, ROM, RAM with programmable regions.
// - Reset map boots from ROM.
// - Decoder register access raises a wait state.
// - Decoder registers written only in privileged mode.
// - Eight 1 kB peripheral selects, stretchable accesses.
// - Illegal or forbidden access raises fault or reset.
// - Software selects processor clock speed.
// - Thirty-two interrupt request channels.
// - Each channel routed to fast or normal line.
// - Vector registers give highest pending channel.
// - Higher channel number always wins.
// - Each channel has its own mask.
// - Channels 0-3: brownout, pin, watchdog events.
// - Channels 4-8: serial error, receive, transmit.
// - Channel 9 bus, channel 10 shared.
// - Channels 11-13: front end events.
// - Channels 14-17: small timers 3 down to 0.
// - Channels 18-22: wide timer, 20 reserved.
// - Channels 23-25: power limit, conversion, faults.
// - Channels 26-31: modulators, fault pin, software.
module sdi_top #(
    parameter int PWAIT_W = 2
) (
    // Clock, reset and clock enable.
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_priv,
    output logic [31:0] reg_rdata,
    output logic cpu_wait,
    // Processor access decode.
    input wire logic [31:0] cpu_addr,
    input wire logic cpu_req,
    input wire logic cpu_user,
    output logic [2:0] mem_sel,
    output logic [7:0] periph_sel,
    output logic cpu_ready,
    output logic sys_fault,
    output logic sys_reset_req,
    output logic [1:0] cpu_clock_sel,
    // Interrupt sources and processor lines.
    input wire logic [31:0] irq_req,
    input wire logic external_pin_request,
    input wire logic fault_pin_request,
    output logic fast_interrupt_line,
    output logic normal_interrupt_line
);
    localparam int NM = sdi_pkg::N_MEM;
    localparam int NP = sdi_pkg::N_PER;
    localparam int PWW = NP * PWAIT_W;

    if (PWAIT_W < 1 || PWAIT_W > 4) begin : g_chk
        $error("PWAIT_W must lie between 1 and 4");
    end

    logic [NM-1:0][31:0] mem_base;
    logic [NM-1:0][3:0] mem_size;
    logic [PWW-1:0] pwait;
    logic [10:0] user_ok;
    logic fault_as_reset;
    logic [1:0] fault;
    logic [1:0] fault_set;
    logic [31:0] mask;
    logic [31:0] fast;
    logic swreq;
    logic [5:0] fvec;
    logic [5:0] nvec;
    logic [31:0] chan;
    logic [31:0] active;
    logic [1:0] pins;
    logic [31:0] next_rdata;
    logic [NM-1:0] next_msel;
    logic [NP-1:0] next_psel;
    logic [2:0] per_idx;
    logic per_hit;
    logic any_hit;
    logic allowed;
    logic [PWAIT_W-1:0] next_wait;
    logic [PWAIT_W-1:0] cnt;
    sdi_pkg::sdi_acc_t acc_st;
    logic dec_reg;

    sdi_vec_if fast_if ();
    sdi_vec_if norm_if ();

    function automatic logic [7:0] reg_off(input logic [7:0] base,
                                           input int idx);
        return 8'(int'(base) + 4 * idx);
    endfunction

    function automatic logic region_hit(input logic [31:0] a,
                                        input logic [31:0] base,
                                        input logic [3:0] code);
        logic [3:0] c;
        logic [4:0] sh;
        c = (code > sdi_pkg::SIZE_CODE_MAX) ? sdi_pkg::SIZE_CODE_MAX : code;
        sh = sdi_pkg::SIZE_LOW_BIT + {1'b0, c};
        return ((a ^ base) & (32'hffff_ffff << sh)) == 32'h0000_0000;
    endfunction

    // Base and size registers sit below the peripheral wait register.
    assign dec_reg = reg_addr < sdi_pkg::OFF_PWAIT;

    // Firmware may remap; reset brings back the boot map.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mem_base <= sdi_pkg::RST_BASE;
            mem_size <= sdi_pkg::RST_SIZE;
        end else if (ce && reg_wr && reg_priv) begin
            for (int i = 0; i < NM; i++) begin
                if (reg_addr == reg_off(sdi_pkg::OFF_BASE0, i)) begin
                    mem_base[i] <= reg_wdata;
                end
                if (reg_addr == reg_off(sdi_pkg::OFF_SIZE0, i)) begin
                    mem_size[i] <= reg_wdata[3:0];
                end
            end
        end
    end

    // The plain port never stalls, so the wait state is flagged out.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            cpu_wait <= 1'b0;
        end else if (ce) begin
            cpu_wait <= (reg_wr || reg_rd) && dec_reg;
        end
    end

    // Management and interrupt control registers.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pwait <= '0;
            user_ok <= sdi_pkg::RST_ACCESS;
            cpu_clock_sel <= sdi_pkg::RST_CLOCK_SEL;
            fault_as_reset <= 1'b0;
            mask <= sdi_pkg::RST_MASK;
            fast <= sdi_pkg::RST_FAST;
            swreq <= 1'b0;
        end else if (ce && reg_wr) begin
            case (reg_addr)
                sdi_pkg::OFF_PWAIT: pwait <= reg_wdata[PWW-1:0];
                sdi_pkg::OFF_ACCESS: user_ok <= reg_wdata[10:0];
                sdi_pkg::OFF_CLOCK: begin
                    cpu_clock_sel <= reg_wdata[1:0];
                    fault_as_reset <= reg_wdata[sdi_pkg::CLOCK_FAR_BIT];
                end
                sdi_pkg::OFF_MASK: mask <= reg_wdata;
                sdi_pkg::OFF_FAST: fast <= reg_wdata;
                sdi_pkg::OFF_SWREQ: swreq <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    // Fault status: a new fault wins over a write-one clear.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fault <= 2'h0;
        end else if (ce) begin
            if (reg_wr && reg_addr == sdi_pkg::OFF_FAULT) begin
                fault <= (fault & ~reg_wdata[1:0]) | fault_set;
            end else begin
                fault <= fault | fault_set;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        for (int i = 0; i < NM; i++) begin
            if (reg_addr == reg_off(sdi_pkg::OFF_BASE0, i)) begin
                next_rdata = mem_base[i];
            end
            if (reg_addr == reg_off(sdi_pkg::OFF_SIZE0, i)) begin
                next_rdata = {28'h0, mem_size[i]};
            end
        end
        case (reg_addr)
            sdi_pkg::OFF_PWAIT: next_rdata = 32'(pwait);
            sdi_pkg::OFF_ACCESS: next_rdata = {21'h0, user_ok};
            sdi_pkg::OFF_CLOCK: begin
                next_rdata = {27'h0, fault_as_reset, 2'h0, cpu_clock_sel};
            end
            sdi_pkg::OFF_FAULT: next_rdata = {30'h0, fault};
            sdi_pkg::OFF_MASK: next_rdata = mask;
            sdi_pkg::OFF_FAST: next_rdata = fast;
            sdi_pkg::OFF_FVEC: next_rdata = {26'h0, fvec};
            sdi_pkg::OFF_NVEC: next_rdata = {26'h0, nvec};
            sdi_pkg::OFF_PEND: next_rdata = chan;
            sdi_pkg::OFF_SWREQ: next_rdata = {31'h0, swreq};
            default: ;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (ce) begin
            reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
        end
    end

    // Peripheral window wins; among memories the highest index wins.
    always_comb begin
        per_hit = cpu_addr[31:sdi_pkg::PER_HIGH_BIT] ==
                  sdi_pkg::PERIPH_BASE[31:sdi_pkg::PER_HIGH_BIT];
        per_idx = cpu_addr[sdi_pkg::PER_HIGH_BIT-1:sdi_pkg::PER_LOW_BIT];
        next_psel = per_hit ? (8'h01 << per_idx) : 8'h00;
        next_msel = '0;
        for (int i = 0; i < NM; i++) begin
            if (!per_hit && region_hit(cpu_addr, mem_base[i],
                                       mem_size[i])) begin
                next_msel = '0;
                next_msel[i] = 1'b1;
            end
        end
        any_hit = per_hit || (|next_msel);
        allowed = !cpu_user || (per_hit ? user_ok[NM + int'(per_idx)]
                                        : |(next_msel & user_ok[NM-1:0]));
        next_wait = per_hit ? pwait[int'(per_idx) * PWAIT_W +: PWAIT_W]
                            : '0;
        fault_set = 2'h0;
        if (ce && acc_st == sdi_pkg::ACC_IDLE && cpu_req) begin
            fault_set[sdi_pkg::FAULT_ILLEGAL] = !any_hit;
            fault_set[sdi_pkg::FAULT_FORBID] = any_hit && !allowed;
        end
    end

    // Access sequencer: grant, hold selects for the stretch, then ready.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            acc_st <= sdi_pkg::ACC_IDLE;
            cnt <= '0;
            mem_sel <= 3'h0;
            periph_sel <= 8'h00;
            cpu_ready <= 1'b0;
            sys_fault <= 1'b0;
            sys_reset_req <= 1'b0;
        end else if (ce) begin
            cpu_ready <= 1'b0;
            sys_fault <= 1'b0;
            sys_reset_req <= 1'b0;
            case (acc_st)
                sdi_pkg::ACC_IDLE: begin
                    if (cpu_req && (!any_hit || !allowed)) begin
                        cpu_ready <= 1'b1;
                        sys_reset_req <= fault_as_reset;
                        sys_fault <= !fault_as_reset;
                    end else if (cpu_req) begin
                        mem_sel <= next_msel;
                        periph_sel <= next_psel;
                        cnt <= next_wait;
                        acc_st <= sdi_pkg::ACC_STRETCH;
                    end
                end
                sdi_pkg::ACC_STRETCH: begin
                    if (cnt == '0) begin
                        cpu_ready <= 1'b1;
                        mem_sel <= 3'h0;
                        periph_sel <= 8'h00;
                        acc_st <= sdi_pkg::ACC_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: acc_st <= sdi_pkg::ACC_IDLE;
            endcase
        end
    end

    sdi_sync #(
        .W(2)
    ) u_pins (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .ce(ce),
        .din({fault_pin_request, external_pin_request}),
        .dout(pins)
    );

    // Fixed channel order from the on-chip sources; front ends, timers
    // and modulators arrive already combined per channel.
    always_comb begin
        chan = irq_req;
        chan[sdi_pkg::CH_EXT_PIN] = pins[0];
        chan[sdi_pkg::CH_RESERVED] = 1'b0;
        chan[sdi_pkg::CH_FAULT_PIN] = pins[1];
        chan[sdi_pkg::CH_SOFTWARE] = swreq;
    end

    // Sources are levels, so firmware must clear them at the source.
    assign active = chan & ~mask;
    assign fast_if.pend = active & fast;
    assign norm_if.pend = active & ~fast;

    sdi_prio u_fast (
        .vec(fast_if)
    );

    sdi_prio u_norm (
        .vec(norm_if)
    );

    // Both lines run independently; the core ranks fast above normal.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            fvec <= 6'h00;
            nvec <= 6'h00;
            fast_interrupt_line <= 1'b0;
            normal_interrupt_line <= 1'b0;
        end else if (ce) begin
            fvec <= {fast_if.valid, fast_if.index};
            nvec <= {norm_if.valid, norm_if.index};
            fast_interrupt_line <= fast_if.valid;
            normal_interrupt_line <= norm_if.valid;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_grant;
        ce && acc_st == sdi_pkg::ACC_IDLE && cpu_req && any_hit && allowed;
    endsequence

    sequence s_finish;
        ce && acc_st == sdi_pkg::ACC_STRETCH && cnt == '0;
    endsequence

    dec_wait_a: assert property (
        ce && (reg_wr || reg_rd) && dec_reg |=> cpu_wait)
        else $error("decoder access gave no wait state");

    dec_priv_a: assert property (
        ce && reg_wr && !reg_priv |=> $stable(mem_base) && $stable(mem_size))
        else $error("user write changed the memory map");

    boot_map_a: assert property (
        $rose(rstn) |-> mem_base == sdi_pkg::RST_BASE)
        else $error("boot map not in place after reset");

    mem_onehot_a: assert property (
        $onehot0(mem_sel) && !(|mem_sel && |periph_sel))
        else $error("more than one select active");

    grant_sel_a: assert property (
        s_grant |=> acc_st == sdi_pkg::ACC_STRETCH &&
            (|mem_sel || $onehot(periph_sel)))
        else $error("granted access raised no select");

    stretch_end_a: assert property (
        s_finish |=> cpu_ready && mem_sel == 3'h0 && periph_sel == 8'h00)
        else $error("stretched access did not complete");

    bad_access_a: assert property (
        ce && acc_st == sdi_pkg::ACC_IDLE && cpu_req && !(any_hit && allowed)
        |=> (sys_fault || sys_reset_req) && cpu_ready && mem_sel == 3'h0)
        else $error("bad access raised no fault");

    mask_block_a: assert property (
        ce && (chan & ~mask & fast) == 32'h0 |=> !fast_interrupt_line)
        else $error("masked channel reached fast line");

    top_channel_a: assert property (
        ce && active[31] && fast[31] |=> fvec == 6'h3f)
        else $error("channel 31 did not win the fast vector");

    normal_route_a: assert property (
        ce && (active & ~fast) != 32'h0 |=> normal_interrupt_line &&
            nvec[sdi_pkg::VEC_VALID_BIT])
        else $error("unmasked normal request raised no line");
endmodule
`default_nettype wire

// [verilog/sdi_pkg.sv]
/*
 * Shared constants of the system decode and interrupt block: register
 * offsets, reset values, field positions and channel assignments.
 * Assumes byte addresses on an 8-bit register offset bus.
 */
`default_nettype none
package sdi_pkg;
    localparam int N_MEM = 3;
    localparam int N_PER = 8;
    localparam int N_CH = 32;
    // Register offsets; base and size groups repeat every four bytes.
    localparam logic [7:0] OFF_BASE0 = 8'h00;
    localparam logic [7:0] OFF_SIZE0 = 8'h0c;
    localparam logic [7:0] OFF_PWAIT = 8'h20;
    localparam logic [7:0] OFF_ACCESS = 8'h24;
    localparam logic [7:0] OFF_CLOCK = 8'h28;
    localparam logic [7:0] OFF_FAULT = 8'h2c;
    localparam logic [7:0] OFF_MASK = 8'h30;
    localparam logic [7:0] OFF_FAST = 8'h34;
    localparam logic [7:0] OFF_FVEC = 8'h38;
    localparam logic [7:0] OFF_NVEC = 8'h3c;
    localparam logic [7:0] OFF_PEND = 8'h40;
    localparam logic [7:0] OFF_SWREQ = 8'h44;
    // Memory select order: flash, ROM, RAM.
    localparam int MEM_FLASH = 0;
    localparam int MEM_ROM = 1;
    localparam int MEM_RAM = 2;
    localparam logic [2:0][31:0] RST_BASE = {
        32'h0008_0000, 32'h0000_0000, 32'h0001_0000};
    localparam logic [2:0][3:0] RST_SIZE = {4'h3, 4'h3, 4'h6};
    localparam logic [4:0] SIZE_LOW_BIT = 5'h0a;
    localparam logic [3:0] SIZE_CODE_MAX = 4'he;
    localparam logic [31:0] PERIPH_BASE = 32'hfff7_0000;
    localparam int PER_LOW_BIT = 10;
    localparam int PER_HIGH_BIT = 13;
    localparam logic [10:0] RST_ACCESS = 11'h7ff;
    localparam logic [1:0] RST_CLOCK_SEL = 2'h0;
    localparam int CLOCK_FAR_BIT = 4;
    localparam int FAULT_ILLEGAL = 0;
    localparam int FAULT_FORBID = 1;
    localparam logic [31:0] RST_MASK = 32'hffff_ffff;
    localparam logic [31:0] RST_FAST = 32'h0000_0000;
    localparam int VEC_VALID_BIT = 5;
    // Fixed channel assignments, 0 lowest and 31 highest precedence.
    localparam int CH_BROWNOUT = 0;
    localparam int CH_EXT_PIN = 1;
    localparam int CH_WD_EXPIRY = 2;
    localparam int CH_WD_HALFWAY = 3;
    localparam int CH_SERIAL_ERR = 4;
    localparam int CH_PMBUS = 9;
    localparam int CH_SHARED = 10;
    localparam int CH_FRONT_END0 = 11;
    localparam int CH_SMALL_TIMER3 = 14;
    localparam int CH_WIDE_OVF = 18;
    localparam int CH_RESERVED = 20;
    localparam int CH_POWER_LIMIT = 23;
    localparam int CH_MODULATOR3 = 26;
    localparam int CH_FAULT_PIN = 30;
    localparam int CH_SOFTWARE = 31;
    typedef enum logic {
        ACC_IDLE = 1'b0,
        ACC_STRETCH = 1'b1
    } sdi_acc_t;
endpackage
`default_nettype wire

// [verilog/sdi_vec_if.sv]
/*
 * Carrier between the interrupt core and a priority encoder.
 * Assumes the encoder answers combinationally.
 */
`timescale 1ns/100ps
`default_nettype none
interface sdi_vec_if;
    logic [31:0] pend;
    logic valid;
    logic [4:0] index;
    modport src(output pend, input valid, input index);
    modport enc(input pend, output valid, output index);
endinterface
`default_nettype wire

// [verilog/sdi_prio.sv]
/*
 * Fixed priority encoder: the highest pending channel number wins.
 * Assumes the pending vector is already masked.
 */
`timescale 1ns/100ps
`default_nettype none
module sdi_prio (
    // Pending vector in, winner out.
    sdi_vec_if.enc vec
);
    always_comb begin
        vec.valid = 1'b0;
        vec.index = 5'h00;
        // Later iterations override, so the higher number wins.
        for (int i = 0; i < 32; i++) begin
            if (vec.pend[i]) begin
                vec.valid = 1'b1;
                vec.index = 5'(i);
            end
        end
    end
endmodule
`default_nettype wire

// [verilog/sdi_sync.sv]
/*
 * Three-stage synchroniser for pin inputs with agreement filter.
 * Assumes inputs are asynchronous to clk_sys.
 */
`timescale 1ns/100ps
`default_nettype none
module sdi_sync #(
    parameter int W = 2
) (
    // Clock, reset and enable.
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // Pin levels in, filtered levels out.
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    if (W < 1) begin : g_chk
        $error("W must be at least 1");
    end

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else if (ce) begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change counts only once the two later stages agree.
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            dout <= '0;
        end else if (ce) begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// [sim/sdi_src_model.sv]
/* Behavioural model of the on-chip interrupt sources and the two pins.
   Assumes the bench commands raise and service pulses on clk_sys. */
`timescale 1ns/100ps
`default_nettype none
module sdi_src_model (
    // Clock.
    input wire logic clk_sys,
    // Commands from the bench.
    input wire logic [31:0] raise,
    input wire logic [31:0] service,
    input wire logic pin_ext,
    input wire logic pin_fault,
    // Request levels toward the block.
    output logic [31:0] irq_req,
    output logic external_pin_request,
    output logic fault_pin_request
);
    initial irq_req = 32'h0;
    // A source holds its level until serviced, as a real flag does.
    always @(posedge clk_sys) begin
        irq_req <= (irq_req | raise) & ~service;
    end
    assign external_pin_request = pin_ext;
    assign fault_pin_request = pin_fault;
endmodule
`default_nettype wire

// [sim/system_decode_interrupt_tb_top.sv]
/* Self-checking testbench of the system decode and interrupt block.
   Assumes the design package, design files and source model. */
`timescale 1ns/100ps
`default_nettype none
module system_decode_interrupt_tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic reg_priv = 1'b1;
    logic [31:0] cpu_addr = 32'h0;
    logic cpu_req = 1'b0;
    logic cpu_user = 1'b0;
    logic [31:0] raise = 32'h0;
    logic [31:0] service = 32'h0;
    logic pin_ext = 1'b0;
    logic pin_fault = 1'b0;
    logic ce = 1'b1;
    logic [31:0] reg_rdata, irq_req;
    logic cpu_wait, cpu_ready, sys_fault, sys_reset_req;
    logic [2:0] mem_sel;
    logic [7:0] periph_sel;
    logic [1:0] cpu_clock_sel;
    logic ext_req, fault_req, fast_line, norm_line;
    logic [13:0] s1;
    logic r2;
    int err_count = 0;
    int check_count = 0;

    always #10 clk_sys = ~clk_sys;

    sdi_top sdi_top_i (
        .clk_sys(clk_sys), .rstn(rstn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_priv(reg_priv), .reg_rdata(reg_rdata),
        .cpu_wait(cpu_wait), .cpu_addr(cpu_addr), .cpu_req(cpu_req),
        .cpu_user(cpu_user), .mem_sel(mem_sel), .periph_sel(periph_sel),
        .cpu_ready(cpu_ready), .sys_fault(sys_fault),
        .sys_reset_req(sys_reset_req), .cpu_clock_sel(cpu_clock_sel),
        .irq_req(irq_req), .external_pin_request(ext_req),
        .fault_pin_request(fault_req), .fast_interrupt_line(fast_line),
        .normal_interrupt_line(norm_line)
    );

    sdi_src_model sdi_src_model_i (
        .clk_sys(clk_sys), .raise(raise), .service(service),
        .pin_ext(pin_ext), .pin_fault(pin_fault), .irq_req(irq_req),
        .external_pin_request(ext_req), .fault_pin_request(fault_req)
    );

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic w);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        w = cpu_wait;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e,
                      input string n);
        logic [31:0] d;
        logic w;
        rd(a, d, w);
        chk(n, e, d);
    endtask

    // Samples the outcome one and two cycles after the request edge.
    task automatic acc(input logic [31:0] a, input logic u);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_user <= u;
        cpu_req <= 1'b1;
        @(posedge clk_sys);
        cpu_req <= 1'b0;
        #1;
        s1 = {sys_reset_req, sys_fault, cpu_ready, periph_sel, mem_sel};
        @(posedge clk_sys);
        #1;
        r2 = cpu_ready;
    endtask

    task automatic settle;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulse_src(input logic [31:0] r, input logic [31:0] s);
        @(posedge clk_sys);
        raise <= r;
        service <= s;
        @(posedge clk_sys);
        raise <= 32'h0;
        service <= 32'h0;
        settle;
    endtask

    task automatic t_reset;
        logic [31:0] d;
        logic w;
        rc(8'h00, 32'h0001_0000, "base_flash");
        rc(8'h04, 32'h0, "base_rom");
        rc(8'h08, 32'h0008_0000, "base_ram");
        rc(sdi_pkg::OFF_SIZE0, 32'h6, "size_flash");
        rc(sdi_pkg::OFF_MASK, 32'hffff_ffff, "mask");
        rc(8'h80, 32'h0, "unmapped");
        rd(8'h00, d, w);
        chk("wait_dec", 32'h1, {31'h0, w});
        rd(sdi_pkg::OFF_MASK, d, w);
        chk("wait_other", 32'h0, {31'h0, w});
    endtask

    task automatic t_priv;
        @(posedge clk_sys);
        reg_priv <= 1'b0;
        wr(8'h04, 32'h0000_4000);
        rc(8'h04, 32'h0, "user_write");
        @(posedge clk_sys);
        reg_priv <= 1'b1;
        wr(8'h04, 32'h0000_4000);
        rc(8'h04, 32'h0000_4000, "priv_write");
        wr(8'h04, 32'h0);
    endtask

    task automatic t_map;
        logic [31:0] adr [3];
        adr = '{32'h0001_0010, 32'h0000_0100, 32'h0008_0010};
        for (int i = 0; i < 3; i++) begin
            acc(adr[i], 1'b0);
            chk("mem_sel", 32'(1 << i), {18'h0, s1});
            chk("mem_ready", 32'h1, {31'h0, r2});
        end
        for (int i = 0; i < 8; i++) begin
            acc(32'hfff7_0000 + 32'(i) * 32'h400, 1'b0);
            chk("periph_sel", 32'(8 << i), {18'h0, s1});
        end
        wr(sdi_pkg::OFF_PWAIT, 32'h2);
        acc(32'hfff7_0000, 1'b0);
        chk("stretch_sel", 32'h8, {18'h0, s1});
        chk("stretch_early", 32'h0, {31'h0, r2});
        repeat (2) @(posedge clk_sys);
        #1;
        chk("stretch_done", 32'h1, {31'h0, cpu_ready});
        wr(sdi_pkg::OFF_PWAIT, 32'h0);
    endtask

    task automatic t_prot;
        wr(sdi_pkg::OFF_ACCESS, 32'h7fe);
        acc(32'h0001_0010, 1'b1);
        chk("forbid", 32'h1800, {18'h0, s1});
        rc(sdi_pkg::OFF_FAULT, 32'h2, "fault_forbid");
        wr(sdi_pkg::OFF_FAULT, 32'h3);
        wr(sdi_pkg::OFF_CLOCK, 32'h12);
        settle;
        chk("clock_sel", 32'h2, {30'h0, cpu_clock_sel});
        acc(32'h4000_0000, 1'b0);
        chk("illegal", 32'h2800, {18'h0, s1});
        rc(sdi_pkg::OFF_FAULT, 32'h1, "fault_illegal");
        wr(sdi_pkg::OFF_ACCESS, 32'h7ff);
        wr(sdi_pkg::OFF_CLOCK, 32'h0);
    endtask

    // A write while the enable is low must leave every register alone.
    task automatic t_freeze;
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(sdi_pkg::OFF_CLOCK, 32'h1);
        ce <= 1'b1;
        rc(sdi_pkg::OFF_CLOCK, 32'h0, "ce_freeze");
    endtask

    task automatic t_irq;
        wr(sdi_pkg::OFF_MASK, 32'h0);
        pulse_src(32'h0000_1020, 32'h0);
        rc(sdi_pkg::OFF_NVEC, 32'h2c, "nvec_high");
        chk("norm_line", 32'h1, {31'h0, norm_line});
        wr(sdi_pkg::OFF_FAST, 32'h0000_1000);
        rc(sdi_pkg::OFF_FVEC, 32'h2c, "fvec");
        rc(sdi_pkg::OFF_NVEC, 32'h25, "nvec_low");
        chk("fast_line", 32'h1, {31'h0, fast_line});
        wr(sdi_pkg::OFF_MASK, 32'h0000_1000);
        settle;
        chk("fast_masked", 32'h0, {31'h0, fast_line});
        rc(sdi_pkg::OFF_NVEC, 32'h25, "nvec_masked");
        pulse_src(32'h0, 32'hffff_ffff);
        wr(sdi_pkg::OFF_MASK, 32'h0);
        pulse_src(32'h0010_0000, 32'h0);
        chk("reserved", 32'h0, {30'h0, fast_line, norm_line});
        pulse_src(32'hffff_ffff, 32'h0);
        rc(sdi_pkg::OFF_PEND, 32'h3fef_fffd, "pend_map");
        pulse_src(32'h0, 32'hffff_ffff);
        wr(sdi_pkg::OFF_SWREQ, 32'h1);
        rc(sdi_pkg::OFF_FVEC, 32'h0, "fvec_idle");
        rc(sdi_pkg::OFF_NVEC, 32'h3f, "software");
        wr(sdi_pkg::OFF_FAST, 32'h8000_0000);
        rc(sdi_pkg::OFF_FVEC, 32'h3f, "fvec_top");
        wr(sdi_pkg::OFF_SWREQ, 32'h0);
        pin_fault <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rc(sdi_pkg::OFF_NVEC, 32'h3e, "fault_pin");
        @(posedge clk_sys);
        pin_fault <= 1'b0;
        pin_ext <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rc(sdi_pkg::OFF_NVEC, 32'h21, "ext_pin");
        wr(sdi_pkg::OFF_MASK, 32'hffff_ffff);
        pin_ext <= 1'b0;
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset;
        t_freeze;
        t_priv;
        t_map;
        t_prot;
        t_irq;
        finish_test;
    end

    // The whole run takes about two hundred cycles, so this is ample.
    initial begin
        #200000;
        err_count++;
        finish_test;
    end
endmodule
`default_nettype wire
